// ### include/cvp_pkg.sv
package cvp_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h29;
    localparam logic [7:0] ADDR_SAT  = 8'h2A;
    localparam logic [7:0] ADDR_CON  = 8'h2B;
    localparam logic [7:0] ADDR_BRI  = 8'h2C;
    localparam logic [7:0] ADDR_STAT = 8'h2D;

    localparam int CTRL_HP_BIT  = 0;
    localparam int CTRL_BYP_BIT = 1;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SAT_RST  = 8'h80;
    localparam logic [7:0] CON_RST  = 8'h80;
    localparam logic [7:0] BRI_RST  = 8'h80;

    // ------------------------------------------------------------------
    // arithmetic constants, coefficients scaled by 1024
    // ------------------------------------------------------------------
    localparam logic [10:0] KY_R  = 11'h132;
    localparam logic [10:0] KY_G  = 11'h259;
    localparam logic [10:0] KY_B  = 11'h075;
    localparam logic [10:0] K_CB  = 11'h24F;
    localparam logic [10:0] K_CR  = 11'h2EB;
    localparam int          K_SHIFT  = 10;
    localparam logic [8:0]  C_MID9   = 9'h100;
    localparam logic [8:0]  HP_MAX   = 9'h1FF;
    localparam int          HP_SHIFT = 4;
    localparam logic [7:0]  BCS_MID  = 8'h80;
    localparam int          BCS_SHIFT = 7;
    localparam logic [7:0]  OUT_MIN  = 8'h01;
    localparam logic [7:0]  OUT_MAX  = 8'hFE;
    localparam logic [2:0]  FILL_LEN = 3'h6;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] c;
        logic       phase;
    } cvp_word_s;

endpackage

// ### include/cvp_stream_if.sv
interface cvp_stream_if;
    cvp_pkg::cvp_word_s data;
    logic               valid;
    logic               ready;

    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface

// ### src/cvp_buf2.sv
module cvp_buf2 (
    input  wire logic       ref_clk,  // pixel clock
    input  wire logic       reset_n,  // synchronous reset
    input  wire logic       ce,       // clock enable
    cvp_stream_if.sink      fill_s,   // words from the pipeline
    cvp_stream_if.source    drain_s,  // words to the receiver
    output logic [1:0]      count     // words held
);
    cvp_pkg::cvp_word_s mem_reg [2];
    cvp_pkg::cvp_word_s mem_next [2];
    logic [1:0]         cnt_reg;
    logic [1:0]         cnt_next;
    logic               vld_reg;
    logic               vld_next;
    logic               rdy_reg;
    logic               rdy_next;
    logic               push;
    logic               pop;

    // ------------------------------------------------------------------
    // two-entry queue, head always in slot 0
    // ------------------------------------------------------------------
    always_comb begin
        push        = fill_s.valid && rdy_reg;
        pop         = vld_reg && drain_s.ready;
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        cnt_next    = cnt_reg;
        case ({push, pop})
            2'b10: begin
                if (cnt_reg == 2'h0) begin
                    mem_next[0] = fill_s.data;
                end else begin
                    mem_next[1] = fill_s.data;
                end
                cnt_next = cnt_reg + 2'h1;
            end
            2'b01: begin
                mem_next[0] = mem_reg[1];
                cnt_next    = cnt_reg - 2'h1;
            end
            2'b11: begin
                if (cnt_reg == 2'h1) begin
                    mem_next[0] = fill_s.data;
                end else begin
                    mem_next[0] = mem_reg[1];
                    mem_next[1] = fill_s.data;
                end
            end
            default: begin
                cnt_next = cnt_reg;
            end
        endcase
        vld_next = cnt_next != 2'h0;
        // ready drops when both slots hold words, stalling the pipeline
        rdy_next = cnt_next != 2'h2;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            cnt_reg    <= 2'h0;
            vld_reg    <= 1'b0;
            rdy_reg    <= 1'b1;
        end else if (ce) begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            cnt_reg    <= cnt_next;
            vld_reg    <= vld_next;
            rdy_reg    <= rdy_next;
        end
    end

    assign fill_s.ready  = rdy_reg;
    assign drain_s.valid = vld_reg;
    assign drain_s.data  = mem_reg[0];
    assign count         = cnt_reg;
endmodule

// ### src/cvp_top.sv
// Function
// - matrix takes 9-bit red, green, blue, gives 9-bit luma and differences
// - luma .299R+.587G+.114B; Cb .5772(B-Y); Cr .7296(R-Y)
// - matrix overall gain is exactly one
// - component inputs bypass the matrix through an equal delay
// - both colour differences are low-pass filtered before downsampling
// - red difference is delayed one clock before the multiplexer
// - phase 0 marks first clock of slot carrying blue difference
// - multiplexed output registered, multiplexer switches on opposite phase
// - luma high-pass gives about 2 dB boost at 6.75 MHz
// - luma high-pass has unity DC gain and clips to 0..511
// - luma high-pass switched by one control bit at address 29h
// - saturation setting of 8 bits scales the colour differences
// - 8-bit contrast gain and brightness offset act on luma
// - adjusted outputs are limited to 1..254
module cvp_top (
    input  wire logic       ref_clk,    // line-locked pixel clock
    input  wire logic       reset_n,    // synchronous reset
    input  wire logic       ce,         // clock enable, freezes state
    input  wire logic [7:0] reg_addr,   // register address
    input  wire logic [7:0] reg_wdata,  // register write data
    input  wire logic       reg_wr,     // write strobe
    input  wire logic       reg_rd,     // read strobe
    output logic      [7:0] reg_rdata,  // read data, cycle after strobe
    input  wire logic [8:0] in_r,       // red, or Cr in component mode
    input  wire logic [8:0] in_g,       // green, or Y in component mode
    input  wire logic [8:0] in_b,       // blue, or Cb in component mode
    input  wire logic       in_valid,   // input sample present
    output logic            in_ready,   // sample taken when both high
    output logic      [7:0] out_y,      // adjusted luma
    output logic      [7:0] out_c,      // multiplexed colour difference
    output logic            out_phase,  // 0 = Cb, first clock of slot
    output logic            out_valid,  // output word present
    input  wire logic       out_ready   // receiver accepts word
);
    typedef struct packed {
        logic [8:0] y_a;
        logic [8:0] b_a;
        logic [8:0] r_a;
        logic       byp_a;
        logic [8:0] y_m;
        logic [8:0] cb_m;
        logic [8:0] cr_m;
        logic [8:0] y_h1;
        logic [8:0] y_h2;
        logic [8:0] cb_h1;
        logic [8:0] cb_h2;
        logic [8:0] cr_h1;
        logic [8:0] cr_h2;
        logic [8:0] cb_l;
        logic [8:0] cr_l;
        logic [8:0] hp;
        logic [8:0] y_pl;
        logic [8:0] cr_d;
        logic [8:0] c_mux;
        logic [8:0] y_fmt;
        logic       mux_ph;
        logic       ph_q;
        logic [7:0] y_o;
        logic [7:0] c_o;
        logic       ph_o;
        logic [2:0] fill;
    } cvp_pipe_s;

    function automatic logic [8:0] cvp_clip9(input logic signed [21:0] v);
        if (v < 22'sd0) begin
            return 9'h000;
        end else if (v > $signed({13'h0000, cvp_pkg::HP_MAX})) begin
            return cvp_pkg::HP_MAX;
        end else begin
            return v[8:0];
        end
    endfunction

    function automatic logic [7:0] cvp_clip8(input logic signed [18:0] v);
        if (v < $signed({11'h000, cvp_pkg::OUT_MIN})) begin
            return cvp_pkg::OUT_MIN;
        end else if (v > $signed({11'h000, cvp_pkg::OUT_MAX})) begin
            return cvp_pkg::OUT_MAX;
        end else begin
            return v[7:0];
        end
    endfunction

    logic [7:0]         ctrl_reg;
    logic [7:0]         ctrl_next;
    logic [7:0]         sat_reg;
    logic [7:0]         sat_next;
    logic [7:0]         con_reg;
    logic [7:0]         con_next;
    logic [7:0]         bri_reg;
    logic [7:0]         bri_next;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    cvp_pipe_s          pipe_reg;
    cvp_pipe_s          pipe_next;
    logic               adv;
    logic               fill_done;
    logic [1:0]         buf_cnt;
    logic               luma_highpass_ctrl;
    logic [19:0]        ysum;
    logic signed [21:0] db;
    logic signed [21:0] dr;
    logic signed [21:0] pb;
    logic signed [21:0] pr;
    logic signed [21:0] hpt;
    logic [10:0]        cb_sum;
    logic [10:0]        cr_sum;
    logic [15:0]        ym;
    logic signed [18:0] yv;
    logic signed [18:0] cd;
    logic signed [18:0] cp;

    cvp_stream_if in_s ();
    cvp_stream_if out_s ();

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    assign luma_highpass_ctrl = ctrl_reg[cvp_pkg::CTRL_HP_BIT];
    assign fill_done          = pipe_reg.fill == cvp_pkg::FILL_LEN;

    always_comb begin
        ctrl_next  = ctrl_reg;
        sat_next   = sat_reg;
        con_next   = con_reg;
        bri_next   = bri_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                cvp_pkg::ADDR_CTRL: ctrl_next = reg_wdata;
                cvp_pkg::ADDR_SAT:  sat_next  = reg_wdata;
                cvp_pkg::ADDR_CON:  con_next  = reg_wdata;
                cvp_pkg::ADDR_BRI:  bri_next  = reg_wdata;
                default:            ctrl_next = ctrl_reg;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                cvp_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
                cvp_pkg::ADDR_SAT:  rdata_next = sat_reg;
                cvp_pkg::ADDR_CON:  rdata_next = con_reg;
                cvp_pkg::ADDR_BRI:  rdata_next = bri_reg;
                cvp_pkg::ADDR_STAT: rdata_next = {5'h00, fill_done, buf_cnt};
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_reg  <= cvp_pkg::CTRL_RST;
            sat_reg   <= cvp_pkg::SAT_RST;
            con_reg   <= cvp_pkg::CON_RST;
            bri_reg   <= cvp_pkg::BRI_RST;
            rdata_reg <= 8'h00;
        end else if (ce) begin
            ctrl_reg  <= ctrl_next;
            sat_reg   <= sat_next;
            con_reg   <= con_next;
            bri_reg   <= bri_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // processing pipeline, moves only when a sample is taken
    // ------------------------------------------------------------------
    // stalling the whole pipe keeps the slot phase tied to sample count
    assign adv = ce && in_valid && in_s.ready;

    always_comb begin
        pipe_next = pipe_reg;
        // matrix stage one: luma, unity gain since coefficients sum to 1024
        ysum = {11'h000, in_r} * {9'h000, cvp_pkg::KY_R}
             + {11'h000, in_g} * {9'h000, cvp_pkg::KY_G}
             + {11'h000, in_b} * {9'h000, cvp_pkg::KY_B};
        pipe_next.byp_a = ctrl_reg[cvp_pkg::CTRL_BYP_BIT];
        if (ctrl_reg[cvp_pkg::CTRL_BYP_BIT]) begin
            pipe_next.y_a = in_g;
        end else begin
            pipe_next.y_a = ysum[cvp_pkg::K_SHIFT +: 9];
        end
        pipe_next.b_a = in_b;
        pipe_next.r_a = in_r;
        // matrix stage two: scaled differences, offset to mid code
        db = $signed({13'h0000, pipe_reg.b_a}) - $signed({13'h0000, pipe_reg.y_a});
        dr = $signed({13'h0000, pipe_reg.r_a}) - $signed({13'h0000, pipe_reg.y_a});
        pb = (db * $signed({11'h000, cvp_pkg::K_CB})) >>> cvp_pkg::K_SHIFT;
        pr = (dr * $signed({11'h000, cvp_pkg::K_CR})) >>> cvp_pkg::K_SHIFT;
        pipe_next.y_m = pipe_reg.y_a;
        if (pipe_reg.byp_a) begin
            pipe_next.cb_m = pipe_reg.b_a;
            pipe_next.cr_m = pipe_reg.r_a;
        end else begin
            pipe_next.cb_m = cvp_clip9(pb + $signed({13'h0000, cvp_pkg::C_MID9}));
            pipe_next.cr_m = cvp_clip9(pr + $signed({13'h0000, cvp_pkg::C_MID9}));
        end
        // downformatter: tap history shared by chroma low-pass and luma filter
        pipe_next.y_h1  = pipe_reg.y_m;
        pipe_next.y_h2  = pipe_reg.y_h1;
        pipe_next.cb_h1 = pipe_reg.cb_m;
        pipe_next.cb_h2 = pipe_reg.cb_h1;
        pipe_next.cr_h1 = pipe_reg.cr_m;
        pipe_next.cr_h2 = pipe_reg.cr_h1;
        cb_sum = {2'h0, pipe_reg.cb_m} + {1'h0, pipe_reg.cb_h1, 1'b0}
               + {2'h0, pipe_reg.cb_h2};
        cr_sum = {2'h0, pipe_reg.cr_m} + {1'h0, pipe_reg.cr_h1, 1'b0}
               + {2'h0, pipe_reg.cr_h2};
        pipe_next.cb_l = cb_sum[10:2];
        pipe_next.cr_l = cr_sum[10:2];
        // -1/16, 18/16, -1/16: unity at DC, 1.25 (about 2 dB) at 6.75 MHz
        hpt = $signed({12'h000, pipe_reg.y_h1, 1'b0})
            - $signed({13'h0000, pipe_reg.y_m})
            - $signed({13'h0000, pipe_reg.y_h2});
        pipe_next.hp = cvp_clip9($signed({13'h0000, pipe_reg.y_h1})
                     + (hpt >>> cvp_pkg::HP_SHIFT));
        pipe_next.y_pl = pipe_reg.y_h1;
        pipe_next.cr_d = pipe_reg.cr_l;
        // mux runs on the opposite phase of the registered output
        pipe_next.mux_ph = !pipe_reg.mux_ph;
        pipe_next.ph_q   = !pipe_reg.mux_ph;
        if (pipe_reg.mux_ph) begin
            pipe_next.c_mux = pipe_reg.cb_l;
        end else begin
            pipe_next.c_mux = pipe_reg.cr_d;
        end
        if (luma_highpass_ctrl) begin
            pipe_next.y_fmt = pipe_reg.hp;
        end else begin
            pipe_next.y_fmt = pipe_reg.y_pl;
        end
        // adjustment stage, wide signed arithmetic then limit
        ym = {8'h00, pipe_reg.y_fmt[8:1]} * {8'h00, con_reg};
        yv = $signed({10'h000, ym[cvp_pkg::BCS_SHIFT +: 9]})
           + $signed({11'h000, bri_reg})
           - $signed({11'h000, cvp_pkg::BCS_MID});
        cd = $signed({11'h000, pipe_reg.c_mux[8:1]})
           - $signed({11'h000, cvp_pkg::BCS_MID});
        cp = (cd * $signed({11'h000, sat_reg})) >>> cvp_pkg::BCS_SHIFT;
        pipe_next.y_o  = cvp_clip8(yv);
        pipe_next.c_o  = cvp_clip8(cp + $signed({11'h000, cvp_pkg::BCS_MID}));
        pipe_next.ph_o = pipe_reg.ph_q;
        if (!fill_done) begin
            pipe_next.fill = pipe_reg.fill + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pipe_reg <= '0;
        end else if (adv) begin
            pipe_reg <= pipe_next;
        end
    end

    // ------------------------------------------------------------------
    // output buffer and ports
    // ------------------------------------------------------------------
    assign in_s.data  = '{y: pipe_reg.y_o, c: pipe_reg.c_o, phase: pipe_reg.ph_o};
    assign in_s.valid = adv && fill_done;
    assign out_s.ready = out_ready;

    cvp_buf2 u_buf (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .ce      (ce),
        .fill_s  (in_s),
        .drain_s (out_s),
        .count   (buf_cnt)
    );

    assign reg_rdata = rdata_reg;
    assign in_ready  = in_s.ready;
    assign out_y     = out_s.data.y;
    assign out_c     = out_s.data.c;
    assign out_phase = out_s.data.phase;
    assign out_valid = out_s.valid;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence byp_two_steps;
        adv && ctrl_reg[cvp_pkg::CTRL_BYP_BIT] ##1 adv;
    endsequence

    matrix_unity_a: assert property (adv && !ctrl_reg[cvp_pkg::CTRL_BYP_BIT]
        && in_r == in_g && in_g == in_b |=> pipe_reg.y_a == $past(in_r))
        else $error("matrix gain not one on grey input");
    bypass_delay_a: assert property (byp_two_steps
        |=> pipe_reg.y_m == $past(in_g, 2))
        else $error("bypass luma delay mismatch");
    hp_dc_unity_a: assert property (adv && pipe_reg.y_m == pipe_reg.y_h1
        && pipe_reg.y_h1 == pipe_reg.y_h2 |=> pipe_reg.hp == $past(pipe_reg.y_h1))
        else $error("luma filter not unity at dc");
    cr_delay_a: assert property (adv |=> pipe_reg.cr_d == $past(pipe_reg.cr_l))
        else $error("red difference delay wrong");
    cb_slot_a: assert property (adv && pipe_reg.mux_ph
        |=> !pipe_reg.ph_q && pipe_reg.c_mux == $past(pipe_reg.cb_l))
        else $error("blue difference not in phase zero");
    hp_bypass_a: assert property (adv && !luma_highpass_ctrl
        |=> pipe_reg.y_fmt == $past(pipe_reg.y_pl))
        else $error("luma filter bypass wrong");
    out_limit_a: assert property (pipe_reg.y_o <= cvp_pkg::OUT_MAX
        && pipe_reg.c_o <= cvp_pkg::OUT_MAX && pipe_reg.fill == 3'h0
        || pipe_reg.y_o >= cvp_pkg::OUT_MIN && pipe_reg.c_o >= cvp_pkg::OUT_MIN
        && pipe_reg.y_o <= cvp_pkg::OUT_MAX && pipe_reg.c_o <= cvp_pkg::OUT_MAX)
        else $error("output outside 1 to 254");
    sat_zero_a: assert property (adv && sat_reg == 8'h00
        |=> pipe_reg.c_o == cvp_pkg::BCS_MID)
        else $error("zero saturation not neutral");
    con_unity_a: assert property (adv && con_reg == cvp_pkg::BCS_MID
        && bri_reg == cvp_pkg::BCS_MID && pipe_reg.y_fmt[8:1] >= cvp_pkg::OUT_MIN
        && pipe_reg.y_fmt[8:1] <= cvp_pkg::OUT_MAX
        |=> pipe_reg.y_o == $past(pipe_reg.y_fmt[8:1]))
        else $error("unity contrast changed luma");
endmodule

// ### test/cvp_adc_model.sv
module cvp_adc_model (
    input  wire logic       clk,    // pixel clock
    output logic      [8:0] r,      // red, or Cr in component mode
    output logic      [8:0] g,      // green, or Y in component mode
    output logic      [8:0] b,      // blue, or Cb in component mode
    output logic            valid,  // sample present
    input  wire logic       ready   // sample taken when both high
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {r, g, b} = 27'h0;
        valid = 1'b0;
    end

    // ------------------------------------------------------------------
    // sample source, prompt or with idle gaps between samples
    // ------------------------------------------------------------------
    // lines left idle after the last sample carry its inverse, so a stale copy
    // taken by mistake shows up in the results
    task automatic send(input int n, input logic [8:0] vr, vg, vb,
                        input int gap);
        for (int i = 0; i < n; i++) begin
            {r, g, b} <= {vr, vg, vb};
            valid <= 1'b1;
            @(posedge clk);
            while (!ready) @(posedge clk);
            if (gap > 0) begin
                valid <= 1'b0;
                repeat (gap) @(posedge clk);
            end
        end
        {r, g, b} <= ~{vr, vg, vb};
        valid <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ### test/component_video_processor_tb.sv
module component_video_processor_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [7:0] ctrl, sat, con, bri;
        logic [8:0] r, g, b;
        logic [7:0] ey, ecb, ecr;
    } cvp_row_s;

    logic        ref_clk   = 1'b0;
    logic        reset_n   = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        out_ready = 1'b1;
    logic        ce        = 1'b1;
    logic [7:0]  reg_rdata, out_y, out_c;
    logic [8:0]  in_r, in_g, in_b;
    logic        in_valid, in_ready, out_phase, out_valid;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    int          takes     = 0;
    int          pops      = 0;
    logic [16:0] words[$];
    cvp_row_s    rows[7] = '{
        '{8'h02,8'h80,8'h80,8'h80,9'h100,9'h100,9'h100,8'h80,8'h80,8'h80},
        '{8'h02,8'h80,8'h80,8'h80,9'h1FF,9'h1FF,9'h000,8'hFE,8'h01,8'hFE},
        '{8'h02,8'h00,8'h40,8'h90,9'h040,9'h100,9'h1C0,8'h50,8'h80,8'h80},
        '{8'h02,8'hFF,8'h80,8'h00,9'h0C0,9'h0A0,9'h180,8'h01,8'hFE,8'h40},
        '{8'h00,8'h80,8'h80,8'h80,9'h0C8,9'h0C8,9'h0C8,8'h64,8'h80,8'h80},
        '{8'h01,8'h80,8'h80,8'h80,9'h1F0,9'h1F0,9'h1F0,8'hF8,8'h80,8'h80},
        '{8'h00,8'h80,8'h80,8'h80,9'h000,9'h000,9'h100,8'h0E,8'hC1,8'h75}};

    always #2.5 ref_clk = ~ref_clk;

    cvp_top uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_r(in_r), .in_g(in_g), .in_b(in_b),
        .in_valid(in_valid), .in_ready(in_ready),
        .out_y(out_y), .out_c(out_c), .out_phase(out_phase),
        .out_valid(out_valid), .out_ready(out_ready));

    cvp_adc_model pm (
        .clk(ref_clk), .r(in_r), .g(in_g), .b(in_b),
        .valid(in_valid), .ready(in_ready));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobes drop and one edge passes, so no signal is set twice a step
    task automatic reg_write(input logic [7:0] a, d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask

    task automatic chk_regs();
        logic [7:0] d;
        logic [7:0] a[5] = '{cvp_pkg::ADDR_CTRL, cvp_pkg::ADDR_SAT,
                             cvp_pkg::ADDR_CON, cvp_pkg::ADDR_BRI, 8'h30};
        logic [7:0] e[5] = '{cvp_pkg::CTRL_RST, cvp_pkg::SAT_RST,
                             cvp_pkg::CON_RST, cvp_pkg::BRI_RST, 8'h00};
        for (int i = 0; i < 5; i++) begin
            reg_read(a[i], d);
            check(d, e[i]);
        end
    endtask

    // a luma step shows overshoot only with the high-pass switched in;
    // the first six words still belong to samples sent before
    task automatic step(input logic [7:0] ctrl, exp_max);
        logic [7:0] top;
        top = 8'h00;
        reg_write(cvp_pkg::ADDR_CTRL, ctrl);
        words.delete();
        pm.send(10, 9'h100, 9'h100, 9'h100, 0);
        pm.send(10, 9'h180, 9'h180, 9'h180, 0);
        repeat (8) @(posedge ref_clk);
        for (int k = 6; k < words.size(); k++)
            if (words[k][16:9] > top)
                top = words[k][16:9];
        check(top, exp_max);
    endtask

    // ------------------------------------------------------------------
    // monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        cycles++;
        if (in_valid && in_ready)
            takes++;
        if (out_valid && out_ready) begin
            pops++;
            words.push_back({out_y, out_c, out_phase});
        end
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] d;
        repeat (10) @(posedge ref_clk);
        check({7'h0, out_valid}, 8'h00);
        check({7'h0, in_ready}, 8'h01);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        reg_write(8'h30, 8'h5A);
        reg_write(cvp_pkg::ADDR_STAT, 8'hFF);
        reg_read(cvp_pkg::ADDR_STAT, d);
        check(d, 8'h00);
        chk_regs();
        // a strobe while the clock enable is low must leave no trace
        ce <= 1'b0;
        reg_write(cvp_pkg::ADDR_SAT, 8'h55);
        ce <= 1'b1;
        reg_read(cvp_pkg::ADDR_SAT, d);
        check(d, cvp_pkg::SAT_RST);
        foreach (rows[i]) begin
            reg_write(cvp_pkg::ADDR_CTRL, rows[i].ctrl);
            reg_write(cvp_pkg::ADDR_SAT, rows[i].sat);
            reg_write(cvp_pkg::ADDR_CON, rows[i].con);
            reg_write(cvp_pkg::ADDR_BRI, rows[i].bri);
            words.delete();
            pm.send(20, rows[i].r, rows[i].g, rows[i].b, i % 2);
            repeat (8) @(posedge ref_clk);
            for (int k = words.size() - 4; k < words.size(); k++) begin
                check(words[k][16:9], rows[i].ey);
                check(words[k][8:1],
                      words[k][0] ? rows[i].ecr : rows[i].ecb);
                check({7'h0, words[k][0]},
                      {7'h0, ~words[k-1][0]});
            end
        end
        step(8'h01, 8'hC4);
        step(8'h00, 8'hC0);
        // receiver stalls: input must be refused, no word may be lost
        out_ready <= 1'b0;
        fork
            pm.send(8, 9'h100, 9'h100, 9'h100, 0);
            begin
                repeat (20) @(posedge ref_clk);
                check({7'h0, in_ready}, 8'h00);
                check({7'h0, out_valid}, 8'h01);
                out_ready <= 1'b1;
            end
        join
        repeat (8) @(posedge ref_clk);
        check(8'(takes - pops), 8'h06);
        reg_read(cvp_pkg::ADDR_STAT, d);
        check(d, 8'h04);
        reg_write(cvp_pkg::ADDR_SAT, 8'h33);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({7'h0, out_valid}, 8'h00);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        chk_regs();
        complete_run();
    end
endmodule
